/* File: design/pgcfg_evt_lane.sv */
// One event input: decodes its control byte into a target and a new value.
module pgcfg_evt_lane (
   // Control byte of this event input.
   input wire logic [pgcfg_pkg::EVT_BYTE_W-1:0] i_ctrl,
   // Incoming event and its level.
   input wire logic i_event,
   input wire logic i_level,
   // Present output register of the group.
   input wire logic [pgcfg_pkg::PINS-1:0] i_port_out,
   // One-hot target and the value to write there.
   output logic [pgcfg_pkg::PINS-1:0] o_hit,
   output logic o_val
);
   import pgcfg_pkg::*;

   logic [EVT_PID_HI-EVT_PID_LO:0] pin_id;
   pgcfg_evt_act_t action;

   assign pin_id = i_ctrl[EVT_PID_HI:EVT_PID_LO]; // R10
   assign action = pgcfg_evt_act_t'(i_ctrl[EVT_ACT_HI:EVT_ACT_LO]);

   // A disabled input produces no target at all, so its events vanish.
   always_comb begin
      o_hit = '0;
      if (i_ctrl[EVT_EN_BIT] && i_event) begin // R8
         o_hit[pin_id] = 1'b1; // R10
      end
      case (action) // R9
         PGCFG_ACT_FOLLOW: o_val = i_level;
         PGCFG_ACT_SET: o_val = 1'b1;
         PGCFG_ACT_CLEAR: o_val = 1'b0;
         PGCFG_ACT_TOGGLE: o_val = ~i_port_out[pin_id];
         default: o_val = 1'b0;
      endcase
   end
endmodule : pgcfg_evt_lane

/* File: design/pgcfg_fsel_mem.sv */
// Sixteen function-select bytes, one per pin pair, with a registered read.
module pgcfg_fsel_mem #(
   parameter int REGS = pgcfg_pkg::FSEL_REGS,
   parameter logic [pgcfg_pkg::FSEL_W-1:0] RESET_LAST =
      pgcfg_pkg::FSEL_RESET
) (
   // Clock, reset and enable.
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // Byte write from software.
   input wire logic i_byte_wr,
   input wire logic [pgcfg_pkg::FSEL_IDX_W-1:0] i_byte_idx,
   input wire logic [pgcfg_pkg::FSEL_W-1:0] i_byte_data,
   // Per-pin nibble write from the multi-pin path.
   input wire logic [2*REGS-1:0] i_nib_wr,
   input wire logic [pgcfg_pkg::FUNC_W-1:0] i_nib_data,
   // Read port.
   input wire logic i_rd,
   input wire logic [pgcfg_pkg::FSEL_IDX_W-1:0] i_rd_idx,
   output logic [pgcfg_pkg::FSEL_W-1:0] o_rdata,
   // Function code of every pin, for the pad multiplexer.
   output logic [2*REGS-1:0][pgcfg_pkg::FUNC_W-1:0] o_codes
);
   import pgcfg_pkg::*;

   logic [REGS-1:0][FSEL_W-1:0] mem;

   // Byte and nibble writes never coincide, as the bus issues one strobe.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         for (int r = 0; r < REGS; r++) begin
            mem[r] <= (r == REGS - 1) ? RESET_LAST : FSEL_RESET; // R15
         end
      end else if (i_ce) begin
         for (int r = 0; r < REGS; r++) begin
            if (i_byte_wr && i_byte_idx == FSEL_IDX_W'(r)) begin
               mem[r] <= i_byte_data; // R11
            end
            for (int h = 0; h < 2; h++) begin
               if (i_nib_wr[2*r+h]) begin
                  mem[r][FUNC_W*h +: FUNC_W] <= i_nib_data; // R1
               end
            end
         end
      end
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_rdata <= FSEL_RESET;
      end else if (i_ce) begin
         o_rdata <= i_rd ? mem[i_rd_idx] : FSEL_RESET;
      end
   end

   // Low nibble serves the even pin, high nibble the odd pin.
   always_comb begin
      for (int p = 0; p < 2*REGS; p++) begin
         o_codes[p] = mem[p/2][FUNC_W*(p%2) +: FUNC_W]; // R12 R13
      end
   end
endmodule : pgcfg_fsel_mem

/* File: design/pgcfg_pkg.sv */
// What this block does
// R1 - Mux-update bit set: load function code into every masked pin selector.
// R2 - Multi-pin function code comes from bits 27:24, used only with mux update.
// R3 - Config update copies bit 22 to drive strength, bit 18 to pull enable.
// R4 - Config update copies bit 17 to input enable, bit 16 to mux enable.
// R5 - Only pins whose mask bit is one in the chosen half-word change.
// R6 - The multi-pin configuration register always reads as zero.
// R7 - Four event inputs, one byte each of the event control word at 0x2C.
// R8 - An event acts only while the top bit of its byte is one.
// R9 - Action 0 follows event level, 1 sets, 2 clears, 3 toggles output.
// R10 - A five-bit pin identifier in the low bits picks target pin 0 to 31.
// R11 - Sixteen byte-wide function-select registers at 0x30 plus n, pin pairs.
// R12 - Bits 7:4 pick the odd pin function, used only while mux enabled.
// R13 - Bits 3:0 pick the even pin function, used only while mux enabled.
// R14 - Codes 0 to 9 pick functions A to J; codes 10 to 15 are reserved.
// R15 - Function selects reset to zero, register 15 of group 0 to 0x06.
// R16 - Each group has its own copy at offset plus group times 0x80.
// R17 - Byte and half-word writes to the multi-pin register are ignored.
// R18 - Bit 31 picks pins 0 to 15 when zero, pins 16 to 31 when one.
// R19 - Bit 30 enables rewriting per-pin settings; zero has no effect.
// R20 - Mux enabled: peripheral drives direction and output, else port does.
// R21 - Several events on one pin in a cycle: highest-numbered input wins.
package pgcfg_pkg;
   // Group geometry.
   localparam int PINS = 32;
   localparam int HALF_PINS = 16;
   localparam int FUNC_W = 4;
   localparam int FUNC_COUNT = 10;
   localparam int EVT_INPUTS = 4;
   localparam int EVT_BYTE_W = 8;
   localparam int FSEL_REGS = 16;
   localparam int FSEL_W = 8;

   // Address layout: byte address, 0x80 bytes per group.
   localparam int ADDR_W = 12;
   localparam int GROUP_SHIFT = 7;
   localparam int OFS_W = 7;
   localparam int GRP_W = ADDR_W - GROUP_SHIFT;
   localparam int FSEL_IDX_W = 4;
   localparam logic [OFS_W-1:0] OFS_MULTI_CFG = 7'h28;
   localparam logic [OFS_W-1:0] OFS_EVT_CTRL = 7'h2C;
   localparam logic [OFS_W-1:0] OFS_FSEL_BASE = 7'h30;
   localparam logic [OFS_W-1:0] OFS_FSEL_LAST = 7'h3F;

   // Multi-pin configuration word fields.
   localparam int BIT_HALF_SEL = 31;
   localparam int BIT_CFG_UPD = 30;
   localparam int BIT_MUX_UPD = 28;
   localparam int FCODE_HI = 27;
   localparam int FCODE_LO = 24;
   localparam int BIT_DRIVE = 22;
   localparam int BIT_PULL = 18;
   localparam int BIT_INPUT_BUFFER_ENABLE = 17;
   localparam int BIT_MUXEN = 16;
   localparam int MASK_HI = 15;

   // Event control byte fields.
   localparam int EVT_EN_BIT = 7;
   localparam int EVT_ACT_HI = 6;
   localparam int EVT_ACT_LO = 5;
   localparam int EVT_PID_HI = 4;
   localparam int EVT_PID_LO = 0;

   // Reset values and function code limits.
   localparam logic [31:0] EVT_CTRL_RESET = 32'h00000000;
   localparam logic [FSEL_W-1:0] FSEL_RESET = 8'h00;
   localparam logic [FSEL_W-1:0] FSEL_LAST_G0_RESET = 8'h06;
   localparam logic [FUNC_W-1:0] FUNC_LAST_VALID = 4'h9;

   typedef enum logic [1:0] {
      PGCFG_ACT_FOLLOW = 2'h0,
      PGCFG_ACT_SET = 2'h1,
      PGCFG_ACT_CLEAR = 2'h2,
      PGCFG_ACT_TOGGLE = 2'h3
   } pgcfg_evt_act_t;

   typedef enum logic [1:0] {
      PGCFG_SIZE_BYTE = 2'h0,
      PGCFG_SIZE_HALF = 2'h1,
      PGCFG_SIZE_WORD = 2'h2
   } pgcfg_size_t;

   typedef enum logic [2:0] {
      PGCFG_RD_NONE = 3'b001,
      PGCFG_RD_EVT = 3'b010,
      PGCFG_RD_FSEL = 3'b100
   } pgcfg_rd_kind_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
      pgcfg_size_t size;
   } pgcfg_bus_req_t;

   typedef struct packed {
      logic drive_strength;
      logic pull_enable;
      logic input_buffer_enable;
      logic mux_enable;
   } pgcfg_pin_cfg_t;

   typedef logic [FUNC_COUNT-1:0][PINS-1:0] pgcfg_fn_vec_t;
   typedef logic [PINS-1:0][FUNC_W-1:0] pgcfg_codes_t;
endpackage : pgcfg_pkg

/* File: design/pgcfg_top.sv */
// Configuration, event and function-select logic of one pin group.
module pgcfg_top #(
   parameter int GROUP_INDEX = 0
) (
   // Clock, reset and clock enable.
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // Register port.
   input wire pgcfg_pkg::pgcfg_bus_req_t i_bus,
   output logic [31:0] o_rdata,
   // Per-pin configuration registers outside this block.
   input wire logic [pgcfg_pkg::PINS-1:0] i_mux_enable,
   output logic [pgcfg_pkg::PINS-1:0] o_cfg_wr_mask,
   output pgcfg_pkg::pgcfg_pin_cfg_t o_cfg_data,
   // Events and the port output register.
   input wire logic [pgcfg_pkg::EVT_INPUTS-1:0] i_event,
   input wire logic [pgcfg_pkg::EVT_INPUTS-1:0] i_event_level,
   input wire logic [pgcfg_pkg::PINS-1:0] i_port_out,
   input wire logic [pgcfg_pkg::PINS-1:0] i_port_dir,
   output logic [pgcfg_pkg::PINS-1:0] o_out_wr_mask,
   output logic [pgcfg_pkg::PINS-1:0] o_out_wr_val,
   // Peripheral functions and the resulting pad control.
   input wire pgcfg_pkg::pgcfg_fn_vec_t i_periph_out,
   input wire pgcfg_pkg::pgcfg_fn_vec_t i_periph_dir,
   output logic [pgcfg_pkg::PINS-1:0] o_pad_out,
   output logic [pgcfg_pkg::PINS-1:0] o_pad_dir
);
   import pgcfg_pkg::*;

   localparam logic [FSEL_W-1:0] LAST_RESET =
      (GROUP_INDEX == 0) ? FSEL_LAST_G0_RESET : FSEL_RESET;

   logic group_hit;
   logic [OFS_W-1:0] ofs;
   logic bus_wr;
   logic bus_rd;
   logic fsel_sel;
   logic multi_wr;
   logic [31:0] wword;
   logic [PINS-1:0] half_mask;
   logic [PINS-1:0] nib_wr;
   logic [31:0] evt_ctrl;
   logic [31:0] evt_rdata;
   pgcfg_rd_kind_t rd_kind;
   logic [FSEL_W-1:0] fsel_rdata;
   pgcfg_codes_t codes;
   logic [EVT_INPUTS-1:0][PINS-1:0] lane_hit;
   logic [EVT_INPUTS-1:0] lane_val;
   logic [PINS-1:0] next_out_mask;
   logic [PINS-1:0] next_out_val;

   // Address decode: the upper bits name the group, the low bits the offset.
   assign group_hit = i_bus.addr[ADDR_W-1:GROUP_SHIFT] ==
      GRP_W'(GROUP_INDEX); // R16
   assign ofs = i_bus.addr[OFS_W-1:0];
   assign bus_wr = i_bus.wr && group_hit;
   assign bus_rd = i_bus.rd && group_hit;
   assign fsel_sel = (ofs >= OFS_FSEL_BASE) && (ofs <= OFS_FSEL_LAST); // R11
   assign wword = i_bus.wdata;

   // A narrow write could land half a configuration, so it is dropped.
   assign multi_wr = bus_wr && (ofs == OFS_MULTI_CFG) &&
      (i_bus.size == PGCFG_SIZE_WORD); // R17

   // The 16-bit mask is placed on the half-word that bit 31 names.
   always_comb begin
      half_mask = '0;
      if (wword[BIT_HALF_SEL]) begin // R18
         half_mask[PINS-1:HALF_PINS] = wword[MASK_HI:0]; // R5
      end else begin
         half_mask[HALF_PINS-1:0] = wword[MASK_HI:0]; // R5
      end
   end

   // Function code write enables for the masked pins.
   assign nib_wr = (multi_wr && wword[BIT_MUX_UPD]) ? half_mask : '0; // R1

   // Per-pin configuration strobe: a one-cycle mask with common data.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_cfg_wr_mask <= '0;
         o_cfg_data <= '0;
      end else if (i_ce) begin
         if (multi_wr && wword[BIT_CFG_UPD]) begin // R19
            o_cfg_wr_mask <= half_mask; // R5
            o_cfg_data.drive_strength <= wword[BIT_DRIVE]; // R3
            o_cfg_data.pull_enable <= wword[BIT_PULL]; // R3
            o_cfg_data.input_buffer_enable <= wword[BIT_INPUT_BUFFER_ENABLE]; // R4
            o_cfg_data.mux_enable <= wword[BIT_MUXEN]; // R4
         end else begin
            o_cfg_wr_mask <= '0;
         end
      end
   end

   // Event control word, written whole at its offset.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         evt_ctrl <= EVT_CTRL_RESET;
      end else if (i_ce && bus_wr && ofs == OFS_EVT_CTRL) begin
         evt_ctrl <= wword; // R7
      end
   end

   // Function-select storage, shared by byte writes and the multi-pin path.
   pgcfg_fsel_mem #(
      .REGS(FSEL_REGS),
      .RESET_LAST(LAST_RESET)
   ) u_fsel (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_byte_wr(bus_wr && fsel_sel),
      .i_byte_idx(ofs[FSEL_IDX_W-1:0]),
      .i_byte_data(wword[FSEL_W-1:0]),
      .i_nib_wr(nib_wr),
      .i_nib_data(wword[FCODE_HI:FCODE_LO]), // R2
      .i_rd(bus_rd && fsel_sel),
      .i_rd_idx(ofs[FSEL_IDX_W-1:0]),
      .o_rdata(fsel_rdata),
      .o_codes(codes)
   );

   // Read side: remember what was read so that the data land one cycle on.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rd_kind <= PGCFG_RD_NONE;
         evt_rdata <= EVT_CTRL_RESET;
      end else if (i_ce) begin
         evt_rdata <= evt_ctrl;
         if (bus_rd && ofs == OFS_EVT_CTRL) begin
            rd_kind <= PGCFG_RD_EVT;
         end else if (bus_rd && fsel_sel) begin
            rd_kind <= PGCFG_RD_FSEL;
         end else begin
            rd_kind <= PGCFG_RD_NONE; // R6
         end
      end
   end

   // The multi-pin register and unmapped offsets answer with zero.
   always_comb begin
      case (rd_kind)
         PGCFG_RD_EVT: o_rdata = evt_rdata;
         PGCFG_RD_FSEL: o_rdata = {{(32-FSEL_W){1'b0}}, fsel_rdata};
         PGCFG_RD_NONE: o_rdata = '0; // R6
         default: o_rdata = '0;
      endcase
   end

   // One decoder per event input, each fed by its own control byte.
   for (genvar e = 0; e < EVT_INPUTS; e++) begin : g_lane
      pgcfg_evt_lane u_lane (
         .i_ctrl(evt_ctrl[EVT_BYTE_W*e +: EVT_BYTE_W]), // R7
         .i_event(i_event[e]),
         .i_level(i_event_level[e]),
         .i_port_out(i_port_out),
         .o_hit(lane_hit[e]),
         .o_val(lane_val[e])
      );
   end

   // Later lanes overwrite earlier ones, so the highest input wins a clash.
   always_comb begin
      next_out_mask = '0;
      next_out_val = i_port_out;
      for (int e = 0; e < EVT_INPUTS; e++) begin
         for (int p = 0; p < PINS; p++) begin
            if (lane_hit[e][p]) begin
               next_out_mask[p] = 1'b1;
               next_out_val[p] = lane_val[e]; // R21
            end
         end
      end
   end

   // Output register write strobe toward the port, one cycle per event.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_out_wr_mask <= '0;
         o_out_wr_val <= '0;
      end else if (i_ce) begin
         o_out_wr_mask <= next_out_mask; // R8
         o_out_wr_val <= next_out_val; // R9
      end
   end

   // Pad control: a reserved code leaves the pin an undriven input.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_pad_out <= '0;
         o_pad_dir <= '0;
      end else if (i_ce) begin
         for (int p = 0; p < PINS; p++) begin
            if (!i_mux_enable[p]) begin
               o_pad_out[p] <= i_port_out[p]; // R20
               o_pad_dir[p] <= i_port_dir[p]; // R20
            end else if (codes[p] <= FUNC_LAST_VALID) begin // R14
               o_pad_out[p] <= i_periph_out[codes[p]][p]; // R12 R13
               o_pad_dir[p] <= i_periph_dir[codes[p]][p]; // R20
            end else begin
               o_pad_out[p] <= 1'b0;
               o_pad_dir[p] <= 1'b0;
            end
         end
      end
   end
endmodule : pgcfg_top

/* File: dv/pgcfg_top_asserts.sv */
// Watches the port side of one pin group for configuration and pad rules.
module pgcfg_top_asserts #(
   parameter int GROUP_INDEX = 0
) (
   // Clock, reset and enable.
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // Register port and per-pin configuration outputs.
   input wire pgcfg_pkg::pgcfg_bus_req_t i_bus,
   input wire logic [31:0] o_rdata,
   input wire logic [pgcfg_pkg::PINS-1:0] i_mux_enable,
   input wire logic [pgcfg_pkg::PINS-1:0] o_cfg_wr_mask,
   input wire pgcfg_pkg::pgcfg_pin_cfg_t o_cfg_data,
   // Events and pads.
   input wire logic [pgcfg_pkg::EVT_INPUTS-1:0] i_event,
   input wire logic [pgcfg_pkg::PINS-1:0] i_port_out,
   input wire logic [pgcfg_pkg::PINS-1:0] i_port_dir,
   input wire logic [pgcfg_pkg::PINS-1:0] o_out_wr_mask,
   input wire logic [pgcfg_pkg::PINS-1:0] o_pad_out,
   input wire logic [pgcfg_pkg::PINS-1:0] o_pad_dir
);
   import pgcfg_pkg::*;
   logic sel;
   logic mpc_wr;
   logic [OFS_W-1:0] ofs;

   // A full-word multi-pin write to this group with the rewrite bit set.
   assign ofs = i_bus.addr[OFS_W-1:0];
   assign sel = i_ce &&
      i_bus.addr[ADDR_W-1:GROUP_SHIFT] == GRP_W'(GROUP_INDEX);
   assign mpc_wr = sel && i_bus.wr && ofs == OFS_MULTI_CFG &&
      i_bus.size == PGCFG_SIZE_WORD && i_bus.wdata[BIT_CFG_UPD];

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);

   // Pad checks skip the edge after reset, whose inputs the flops never saw.
   a_mpc_reads_zero: assert property (
      sel && i_bus.rd && ofs == OFS_MULTI_CFG |=> o_rdata == 32'h0)
      else $error("multi-pin register read back nonzero");
   a_other_group_quiet: assert property (
      i_ce && i_bus.wr && !sel |=> o_cfg_wr_mask == 32'h0)
      else $error("write to another group changed pins");
   a_cfg_needs_word: assert property (
      $past(i_ce) && o_cfg_wr_mask != 32'h0 |-> $past(mpc_wr))
      else $error("pin config pulse without word write");
   a_cfg_mask_half: assert property (
      mpc_wr |=> o_cfg_wr_mask == ($past(i_bus.wdata[BIT_HALF_SEL]) ?
         {$past(i_bus.wdata[MASK_HI:0]), 16'h0000} :
         {16'h0000, $past(i_bus.wdata[MASK_HI:0])}))
      else $error("pin config mask wrong");
   a_cfg_data_bits: assert property (
      mpc_wr |=> o_cfg_data == $past({i_bus.wdata[BIT_DRIVE],
         i_bus.wdata[BIT_PULL], i_bus.wdata[BIT_INPUT_BUFFER_ENABLE],
         i_bus.wdata[BIT_MUXEN]}))
      else $error("pin config data wrong");
   a_evt_needs_event: assert property (
      $past(i_ce) && o_out_wr_mask != 32'h0 |-> $past(i_event) != 4'h0)
      else $error("output write without event");
   a_pad_port_out: assert property (
      $past(i_ce) && $past(i_rst_b) |->
      ((o_pad_out ^ $past(i_port_out)) & ~$past(i_mux_enable)) == 32'h0)
      else $error("port output not on pad");
   a_pad_port_dir: assert property (
      $past(i_ce) && $past(i_rst_b) |->
      ((o_pad_dir ^ $past(i_port_dir)) & ~$past(i_mux_enable)) == 32'h0)
      else $error("port direction not on pad");

   // Main scenarios.
   c_mpc_write: cover property (mpc_wr);
   c_event_hit: cover property (i_event != 4'h0 ##1 o_out_wr_mask != 32'h0);
   c_pad_periph: cover property (i_mux_enable != 32'h0 && o_pad_out != 32'h0);
endmodule : pgcfg_top_asserts

bind pgcfg_top pgcfg_top_asserts #(.GROUP_INDEX(GROUP_INDEX)) u_asserts (
   .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_bus(i_bus),
   .o_rdata(o_rdata), .i_mux_enable(i_mux_enable),
   .o_cfg_wr_mask(o_cfg_wr_mask), .o_cfg_data(o_cfg_data),
   .i_event(i_event), .i_port_out(i_port_out), .i_port_dir(i_port_dir),
   .o_out_wr_mask(o_out_wr_mask), .o_pad_out(o_pad_out),
   .o_pad_dir(o_pad_dir));

/* File: dv/tb_pgcfg_top.sv */
// Register-level bench for the pin group configuration block.
module tb_pgcfg_top;
   timeunit 1ns;
   timeprecision 100ps;
   import pgcfg_pkg::*;
   localparam pgcfg_size_t W = PGCFG_SIZE_WORD;
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_ce = 1'b1;
   pgcfg_bus_req_t bus = '0;
   logic [31:0] rdata;
   logic [PINS-1:0] mux_en = '0, cfg_mask, port_out = '0, port_dir = '0;
   logic [PINS-1:0] out_mask, out_val, pad_out, pad_dir;
   pgcfg_pin_cfg_t cfg_data;
   logic [3:0] ev = '0, ev_lvl = '0;
   pgcfg_fn_vec_t p_out = '0, p_dir = '0;
   int err_count = 0;
   int check_count = 0;
   // Multi-pin writes: two good ones, byte, no rewrite, half-word.
   logic [31:0] mw [5] = '{32'hC041A5A5, 32'h400600F0, 32'h404700FF,
      32'h004700FF, 32'h404700FF};
   pgcfg_size_t msz [5] = '{W, W, PGCFG_SIZE_BYTE, W, PGCFG_SIZE_HALF};
   logic [31:0] em [5] = '{32'hA5A50000, 32'h000000F0, 32'h0, 32'h0, 32'h0};
   logic [3:0] ed [2] = '{4'h9, 4'h6};

   pgcfg_top #(.GROUP_INDEX(0)) u_dut (
      .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_bus(bus),
      .o_rdata(rdata), .i_mux_enable(mux_en), .o_cfg_wr_mask(cfg_mask),
      .o_cfg_data(cfg_data), .i_event(ev), .i_event_level(ev_lvl),
      .i_port_out(port_out), .i_port_dir(port_dir),
      .o_out_wr_mask(out_mask), .o_out_wr_val(out_val),
      .i_periph_out(p_out), .i_periph_dir(p_dir),
      .o_pad_out(pad_out), .o_pad_dir(pad_dir));

   // The clock runs at 40 MHz.
   always #12.5 i_mclk = ~i_mclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // One strobe cycle; returns just after the edge that took it.
   task automatic bus_op(input logic wr, input logic [11:0] a,
         input logic [31:0] d, input pgcfg_size_t s);
      @(posedge i_mclk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.size <= s;
      bus.wr <= wr;
      bus.rd <= !wr;
      @(posedge i_mclk);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      #1;
   endtask : bus_op

   task automatic fire(input logic [3:0] e, input logic [3:0] lv);
      @(posedge i_mclk);
      ev <= e;
      ev_lvl <= lv;
      @(posedge i_mclk);
      ev <= 4'h0;
      #1;
   endtask : fire

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   // A hang costs a mismatch; the tests need under a hundred cycles.
   initial begin
      repeat (3000) @(posedge i_mclk);
      err_count++;
      give_verdict();
   end

   // Main sequence.
   initial begin
      repeat (5) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      bus_op(0, 12'h03F, 32'h0, W); chk(rdata, 32'h06);
      bus_op(0, 12'h030, 32'h0, W); chk(rdata, 32'h00);
      bus_op(0, 12'h02C, 32'h0, W); chk(rdata, 32'h0);
      $display("reset values done");
      bus_op(1, 12'h033, 32'h93, PGCFG_SIZE_BYTE);
      bus_op(1, 12'h0B3, 32'h11, PGCFG_SIZE_BYTE);
      bus_op(0, 12'h033, 32'h0, W); chk(rdata, 32'h93);
      bus_op(0, 12'h028, 32'h0, W); chk(rdata, 32'h0);
      bus_op(0, 12'h000, 32'h0, W); chk(rdata, 32'h0);
      $display("register access done");
      for (int i = 0; i < 5; i++) begin
         bus_op(1, 12'h028, mw[i], msz[i]);
         chk(cfg_mask, em[i]);
         if (i < 2) chk({28'h0, cfg_data}, {28'h0, ed[i]});
      end
      bus_op(1, 12'h0A8, mw[0], W); chk(cfg_mask, 32'h0);
      $display("pin config writes done");
      // Codes land in the selectors of masked pins only.
      bus_op(1, 12'h028, 32'h17000006, W);
      bus_op(1, 12'h028, 32'h93008000, W);
      bus_op(1, 12'h028, 32'h05000001, W);
      bus_op(0, 12'h030, 32'h0, W); chk(rdata, 32'h70);
      bus_op(0, 12'h031, 32'h0, W); chk(rdata, 32'h07);
      bus_op(0, 12'h03F, 32'h0, W); chk(rdata, 32'h36);
      $display("mux writes done");
      // Pin 9 gets a reserved code and must stay undriven.
      // Pin 7 holds code 9, the last valid one, and must be driven.
      bus_op(1, 12'h034, 32'hB0, PGCFG_SIZE_BYTE);
      @(posedge i_mclk);
      p_out <= '1;
      p_dir <= '1;
      port_out <= 32'h100;
      port_dir <= 32'h100;
      mux_en <= 32'h80000286;
      repeat (2) @(posedge i_mclk);
      p_out[7] <= '0;
      #1;
      chk(pad_out, 32'h80000186);
      chk(pad_dir, 32'h80000186);
      repeat (2) @(posedge i_mclk);
      i_ce <= 1'b0;
      port_out <= 32'h0;
      #1;
      chk(pad_out, 32'h80000180);
      repeat (3) @(posedge i_mclk);
      #1;
      chk(pad_out, 32'h80000180);
      @(posedge i_mclk);
      i_ce <= 1'b1;
      // Pin 31 low so that a toggle differs from a clear.
      port_out <= 32'h7FFFFFFF;
      $display("pads done");
      // Each lane in its own byte, one action each, targets 1 to 31.
      for (int a = 0; a < 4; a++) begin
         bus_op(1, 12'h02C,
            {24'h0, 1'b1, a[1:0], 5'(a * 10 + 1)} << (8 * a), W);
         // A low level tells the follow action from leaving the pin high.
         fire(4'h1 << a, 4'h0);
         chk(out_mask, 32'h1 << (a * 10 + 1));
         chk(out_val & out_mask, {31'h0, a[0]} << (a * 10 + 1));
      end
      bus_op(1, 12'h02C, 32'h00000025, W);
      fire(4'h1, 4'h0); chk(out_mask, 32'h0);
      bus_op(1, 12'h02C, 32'hC50000A5, W);
      fire(4'h9, 4'h0); chk(out_mask, 32'h20);
      chk(out_val & 32'h20, 32'h0);
      bus_op(0, 12'h02C, 32'h0, W); chk(rdata, 32'hC50000A5);
      $display("events done");
      give_verdict();
   end
endmodule : tb_pgcfg_top
